// [acr_conv_ctrl.sv]
`timescale 1ns/10ps
// Behaviour
// - sinc1 and FIR modes give settled data after one conversion period.
// - first latency runs from start event and includes the start delay.
// - continuous mode completes each later conversion one data period apart.
// - first latency follows filter mode and data rate.
// - delay field 0001 gives 50 us nominal; all times except the 1000 ns clock-loss timeout scale with master clock.
// - each start event waits the programmable delay before filtering.
// - toggling external clock is detected and selected automatically.
// - selected clock source is readable as a status flag.
// - without external clock the internal oscillator runs from power-on.
// - reset comes from power-on, the reset pin or a reset command.
// - any reset restores conversion control and registers; only power-on resets the bus interface.
// - every reset sets a sticky flag that software clears.
// - start pin high at end of reset begins conversions automatically.
// - after power-on wait 2^16 master ticks before accepting the bus.
// - data ready held low during power-on wait, then driven high.
// - first conversion starts 512 master ticks after data ready rises.
// - data ready goes high when a conversion is started, or one tick before each later continuous result; low when data ready.
// - start, stop and reset commands act when their write is accepted.
module acr_conv_ctrl #(
  parameter int POR_CYCLES = acr_pkg::ACR_POR_CYCLES,
  parameter int TICK_SHIFT = 0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start_pin,
  input wire logic reset_pin_n,
  input wire logic ext_clock_in,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic data_ready_n,
  output logic clock_external
);
  logic start_lvl;
  logic start_rise;
  logic start_fall;
  logic rpin_lvl;
  logic rpin_rise;
  logic ext_rise;

  acr_sync_edge u_start_sync (
    .clk(clk), .rst_b(rst_b), .async_in(start_pin),
    .level(start_lvl), .rise(start_rise), .fall(start_fall)
  );
  acr_sync_edge #(.IDLE_LEVEL(1'b1)) u_rpin_sync (
    .clk(clk), .rst_b(rst_b), .async_in(reset_pin_n),
    .level(rpin_lvl), .rise(rpin_rise), .fall()
  );
  acr_sync_edge u_ext_sync (
    .clk(clk), .rst_b(rst_b), .async_in(ext_clock_in),
    .level(), .rise(ext_rise), .fall()
  );

  // clock source selection and master tick
  logic [7:0] osc_cnt_reg;
  logic [7:0] osc_cnt_next;
  logic osc_tick_reg;
  logic osc_tick_next;
  logic [9:0] loss_cnt_reg;
  logic [9:0] loss_cnt_next;
  logic ext_sel_reg;
  logic ext_sel_next;
  logic tick;

  always_comb begin
    osc_cnt_next = osc_cnt_reg + 8'h01;
    osc_tick_next = 1'b0;
    if (osc_cnt_reg == 8'(acr_pkg::ACR_INT_OSC_DIV - 1)) begin
      osc_cnt_next = 8'h00;
      osc_tick_next = 1'b1;
    end
    loss_cnt_next = loss_cnt_reg;
    ext_sel_next = ext_sel_reg;
    if (ext_rise) begin
      loss_cnt_next = 10'h000;
      ext_sel_next = 1'b1;
    end else if (loss_cnt_reg == 10'(acr_pkg::ACR_EXT_LOSS_CYCLES)) begin
      ext_sel_next = 1'b0;
    end else begin
      loss_cnt_next = loss_cnt_reg + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      osc_cnt_reg <= 8'h00;
      osc_tick_reg <= 1'b0;
      loss_cnt_reg <= 10'(acr_pkg::ACR_EXT_LOSS_CYCLES);
      ext_sel_reg <= 1'b0;
    end else begin
      osc_cnt_reg <= osc_cnt_next;
      osc_tick_reg <= osc_tick_next;
      loss_cnt_reg <= loss_cnt_next;
      ext_sel_reg <= ext_sel_next;
    end
  end

  // one master clock period, from whichever source is selected
  assign tick = ext_sel_reg ? ext_rise : osc_tick_reg;

  // register bus
  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic wr_ok;
  logic ready_reg;
  logic [15:0] ctrl_reg;
  logic rstflag_reg;
  logic data_ready_n_n_reg;
  logic [15:0] count_reg;
  acr_pkg::acr_state_type state_reg;

  // the write takes effect at the edge where the master sees waitrequest low
  assign wr_ok = avs_write && !wait_reg;

  always_comb begin
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    // stall the bus until the power-on wait is over
    if ((avs_read || avs_write) && wait_reg && ready_reg) begin
      wait_next = 1'b0;
      rdata_next = 32'h0000_0000;
      case (avs_address)
        acr_pkg::ACR_OFS_CTRL: rdata_next[15:0] = ctrl_reg;
        acr_pkg::ACR_OFS_STATUS: begin
          rdata_next[acr_pkg::ACR_ST_RESET_BIT] = rstflag_reg;
          rdata_next[acr_pkg::ACR_ST_CLKEXT_BIT] = ext_sel_reg;
          rdata_next[acr_pkg::ACR_ST_DATA_READY_N_BIT] = data_ready_n_n_reg;
          rdata_next[acr_pkg::ACR_ST_BUSY_BIT] = (state_reg != acr_pkg::ACR_ST_IDLE);
          rdata_next[acr_pkg::ACR_ST_READY_BIT] = ready_reg;
        end
        acr_pkg::ACR_OFS_COUNT: rdata_next[15:0] = count_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // conversion control
  logic cmd_start;
  logic cmd_stop;
  logic cmd_rst;
  logic pin_rst;
  logic soft_rst;
  logic start_evt;
  logic [2:0] rpin_cnt_reg;
  logic [2:0] rpin_cnt_next;
  logic ready_next;
  logic [15:0] ctrl_next;
  logic rstflag_next;
  logic data_ready_n_n_next;
  logic [15:0] count_next;
  logic run_reg;
  logic run_next;
  acr_pkg::acr_state_type state_next;
  logic [25:0] cnt_reg;
  logic [25:0] cnt_next;
  logic [4:0] rate_idx;
  logic [2:0] mode;
  logic [21:0] period_ticks;
  logic [25:0] settle_ticks;
  logic [12:0] delay_ticks;

  assign cmd_start = wr_ok && avs_address == acr_pkg::ACR_OFS_CMD
                     && avs_writedata[acr_pkg::ACR_CMD_START_BIT];
  assign cmd_stop = wr_ok && avs_address == acr_pkg::ACR_OFS_CMD
                    && avs_writedata[acr_pkg::ACR_CMD_STOP_BIT];
  assign cmd_rst = wr_ok && avs_address == acr_pkg::ACR_OFS_CMD
                   && avs_writedata[acr_pkg::ACR_CMD_RESET_BIT];
  // a pin pulse shorter than four master ticks is taken as a glitch
  assign pin_rst = rpin_rise
                   && rpin_cnt_reg == 3'(acr_pkg::ACR_RST_PIN_MIN_TICKS);
  assign soft_rst = pin_rst || cmd_rst;
  assign start_evt = start_rise || cmd_start;

  assign mode = ctrl_reg[acr_pkg::ACR_CTRL_MODE_LSB +: 3];
  assign rate_idx = ctrl_reg[acr_pkg::ACR_CTRL_RATE_LSB +: 5];

  always_comb begin
    logic [21:0] raw;
    raw = (rate_idx < 5'(acr_pkg::ACR_NUM_RATES)) ?
          acr_pkg::ACR_PERIOD_TICKS[rate_idx] : acr_pkg::ACR_PERIOD_TICKS[0];
    period_ticks = raw >> TICK_SHIFT;
    if (period_ticks < 22'h000002) begin
      period_ticks = 22'h000002;
    end
    // sinc1 and FIR settle in a single period, higher orders take more
    settle_ticks = 26'(period_ticks)
                   * 26'(acr_pkg::ACR_FILTER_ORDER[(mode > acr_pkg::ACR_MODE_FIR) ?
                     3'h0 : mode]);
    delay_ticks = 13'(ctrl_reg[acr_pkg::ACR_CTRL_DELAY_LSB +: 4])
                  * 13'(acr_pkg::ACR_DELAY_UNIT_TICKS);
  end

  always_comb begin
    rpin_cnt_next = rpin_cnt_reg;
    if (rpin_lvl) begin
      rpin_cnt_next = 3'h0;
    end else if (tick && rpin_cnt_reg != 3'(acr_pkg::ACR_RST_PIN_MIN_TICKS)) begin
      rpin_cnt_next = rpin_cnt_reg + 3'h1;
    end

    ready_next = ready_reg;
    ctrl_next = ctrl_reg;
    data_ready_n_n_next = data_ready_n_n_reg;
    count_next = count_reg;
    run_next = run_reg;
    state_next = state_reg;
    cnt_next = cnt_reg;
    // a new reset sets the flag even in the cycle software clears it
    rstflag_next = rstflag_reg;
    if (wr_ok && avs_address == acr_pkg::ACR_OFS_STATUS
        && avs_writedata[acr_pkg::ACR_ST_RESET_BIT]) begin
      rstflag_next = 1'b0;
    end
    if (soft_rst) begin
      rstflag_next = 1'b1;
    end

    // a reset inside the power-on wait lets that wait run on, else the bus never opens
    if (soft_rst && ready_reg) begin
      ctrl_next = acr_pkg::ACR_CTRL_RESET;
      data_ready_n_n_next = 1'b1;
      count_next = 16'h0000;
      run_next = 1'b0;
      state_next = acr_pkg::ACR_ST_HOLD;
      cnt_next = 26'(acr_pkg::ACR_START_HOLD_TICKS);
    end else begin
      if (wr_ok && avs_address == acr_pkg::ACR_OFS_CTRL) begin
        ctrl_next = avs_writedata[15:0];
      end
      if (cmd_stop || start_fall) begin
        run_next = 1'b0;
      end
      if (start_evt && state_reg != acr_pkg::ACR_ST_POR) begin
        // a start also restarts any conversion in progress
        data_ready_n_n_next = 1'b1;
        run_next = 1'b1;
        if (delay_ticks == 13'h0000) begin
          state_next = acr_pkg::ACR_ST_SETTLE;
          cnt_next = settle_ticks;
        end else begin
          state_next = acr_pkg::ACR_ST_DELAY;
          cnt_next = 26'(delay_ticks);
        end
      end else if (tick) begin
        case (state_reg)
          acr_pkg::ACR_ST_POR: begin
            cnt_next = cnt_reg - 26'h1;
            if (cnt_reg == 26'h1) begin
              ready_next = 1'b1;
              data_ready_n_n_next = 1'b1;
              state_next = acr_pkg::ACR_ST_HOLD;
              cnt_next = 26'(acr_pkg::ACR_START_HOLD_TICKS);
            end
          end
          acr_pkg::ACR_ST_HOLD: begin
            cnt_next = cnt_reg - 26'h1;
            if (cnt_reg == 26'h1) begin
              if (start_lvl) begin
                run_next = 1'b1;
                data_ready_n_n_next = 1'b1;
                state_next = acr_pkg::ACR_ST_DELAY;
                cnt_next = (delay_ticks == 13'h0000) ? 26'h1 : 26'(delay_ticks);
              end else begin
                state_next = acr_pkg::ACR_ST_IDLE;
              end
            end
          end
          acr_pkg::ACR_ST_DELAY: begin
            cnt_next = cnt_reg - 26'h1;
            if (cnt_reg == 26'h1) begin
              state_next = acr_pkg::ACR_ST_SETTLE;
              cnt_next = settle_ticks;
            end
          end
          acr_pkg::ACR_ST_SETTLE, acr_pkg::ACR_ST_RUN: begin
            cnt_next = cnt_reg - 26'h1;
            if (state_reg == acr_pkg::ACR_ST_RUN && cnt_reg == 26'h2) begin
              data_ready_n_n_next = 1'b1;
            end
            if (cnt_reg == 26'h1) begin
              data_ready_n_n_next = 1'b0;
              count_next = count_reg + 16'h0001;
              // stop only takes effect once the running conversion is done
              if (run_reg && ctrl_reg[acr_pkg::ACR_CTRL_CONT_BIT]) begin
                state_next = acr_pkg::ACR_ST_RUN;
                cnt_next = 26'(period_ticks);
              end else begin
                run_next = 1'b0;
                state_next = acr_pkg::ACR_ST_IDLE;
              end
            end
          end
          acr_pkg::ACR_ST_IDLE: begin
            cnt_next = cnt_reg;
          end
          default: begin
            state_next = acr_pkg::ACR_ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rpin_cnt_reg <= 3'h0;
      ready_reg <= 1'b0;
      ctrl_reg <= acr_pkg::ACR_CTRL_RESET;
      rstflag_reg <= 1'b1;
      data_ready_n_n_reg <= 1'b0;
      count_reg <= 16'h0000;
      run_reg <= 1'b0;
      state_reg <= acr_pkg::ACR_ST_POR;
      cnt_reg <= 26'(POR_CYCLES);
    end else begin
      rpin_cnt_reg <= rpin_cnt_next;
      ready_reg <= ready_next;
      ctrl_reg <= ctrl_next;
      rstflag_reg <= rstflag_next;
      data_ready_n_n_reg <= data_ready_n_n_next;
      count_reg <= count_next;
      run_reg <= run_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign data_ready_n = data_ready_n_n_reg;
  assign clock_external = ext_sel_reg;
endmodule : acr_conv_ctrl

// [acr_conv_ctrl_sva.sv]
`timescale 1ns/10ps
module acr_conv_ctrl_sva #(
  parameter int POR_CYCLES = 16,
  parameter int TICK_SHIFT = 0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start_pin,
  input wire logic reset_pin_n,
  input wire logic ext_clock_in,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic data_ready_n,
  input wire logic clock_external
);
  logic seen_reg, seen_next, ext_reg, ext_next, cmd_ok;
  logic [31:0] wait_reg, wait_next;
  logic [15:0] pin_reg, pin_next, still_reg, still_next;
  assign cmd_ok = avs_write && !avs_waitrequest && avs_address == acr_pkg::ACR_OFS_CMD;
  always_comb begin
    seen_next = seen_reg | data_ready_n;
    wait_next = seen_reg ? wait_reg : wait_reg + 32'h1;
    pin_next = reset_pin_n ? 16'h0 : pin_reg + 16'h1;
    ext_next = ext_clock_in;
    still_next = (ext_clock_in != ext_reg) ? 16'h0 : still_reg + {15'h0, still_reg != 16'hFFFF};
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      seen_reg <= 1'b0;
      wait_reg <= 32'h0;
      pin_reg <= 16'h0;
      ext_reg <= 1'b0;
      still_reg <= 16'h0;
    end else begin
      seen_reg <= seen_next;
      wait_reg <= wait_next;
      pin_reg <= pin_next;
      ext_reg <= ext_next;
      still_reg <= still_next;
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);
  wait_one_a:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long waitrequest");
  unmapped_zero_a:
    assert property (avs_read && !avs_waitrequest && avs_address == 4'h1 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  reset_low_a:
    assert property (disable iff (1'b0) !rst_b |=> !data_ready_n && avs_waitrequest)
    else $error("bad state after reset");
  por_stall_a:
    assert property (!seen_reg && !data_ready_n |-> avs_waitrequest) else $error("bus open early");
  por_len_a:
    assert property ($rose(data_ready_n) && !seen_reg |-> wait_reg >= 32'(POR_CYCLES * 8))
    else $error("power-on wait too short");
  start_pin_a:
    assert property ($rose(start_pin) && seen_reg |-> ##[1:8] data_ready_n)
    else $error("start pin not seen");
  cmd_start_a:
    assert property (cmd_ok && avs_writedata[0] |-> ##[1:3] data_ready_n) else $error("no start");
  cmd_reset_a:
    assert property (cmd_ok && avs_writedata[2] |-> ##[1:3] data_ready_n) else $error("no reset");
  pin_reset_a:
    assert property ($rose(reset_pin_n) && pin_reg >= 16'h00C8 |-> ##[2:8] data_ready_n)
    else $error("pin reset missed");
  clk_loss_a:
    assert property (still_reg > 16'h012C |-> !clock_external) else $error("dead clock kept");
  clk_sel_a:
    assert property ($rose(ext_clock_in) && !clock_external |-> ##[1:300] clock_external)
    else $error("clock not selected");
endmodule : acr_conv_ctrl_sva

bind acr_conv_ctrl acr_conv_ctrl_sva #(.POR_CYCLES(POR_CYCLES), .TICK_SHIFT(TICK_SHIFT)) u_sva (
  .clk(clk), .rst_b(rst_b), .start_pin(start_pin), .reset_pin_n(reset_pin_n),
  .ext_clock_in(ext_clock_in), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .data_ready_n(data_ready_n),
  .clock_external(clock_external));

// [acr_ext_clk_src.sv]
`timescale 1ns/10ps
module acr_ext_clk_src (
  input wire logic enable,
  output logic ext_clock_in
);
  logic osc = 1'b0;
  // phase offset keeps source edges clear of the system clock edges
  initial #7 forever #32 osc = ~osc;
  // a stopped source reads as the pin strapped to ground
  assign ext_clock_in = enable & osc;
endmodule : acr_ext_clk_src

// [acr_pkg.sv]
package acr_pkg;
  // system clock
  localparam longint ACR_CLK_HZ = 250000000;
  // nominal master clock that all tick tables refer to
  localparam longint ACR_NOMINAL_FCLK_HZ = 7372800;
  localparam int ACR_INT_OSC_DIV = int'(ACR_CLK_HZ / ACR_NOMINAL_FCLK_HZ);
  // external clock declared lost after this long without a rising edge
  localparam longint ACR_EXT_LOSS_NS = 1000;
  localparam int ACR_EXT_LOSS_CYCLES = int'((ACR_EXT_LOSS_NS * ACR_CLK_HZ) / 1000000000);

  // register byte offsets
  localparam logic [3:0] ACR_OFS_CTRL = 4'h0;
  localparam logic [3:0] ACR_OFS_STATUS = 4'h4;
  localparam logic [3:0] ACR_OFS_CMD = 4'h8;
  localparam logic [3:0] ACR_OFS_COUNT = 4'hC;

  // control register fields
  localparam int ACR_CTRL_MODE_LSB = 0;
  localparam int ACR_CTRL_RATE_LSB = 3;
  localparam int ACR_CTRL_CONT_BIT = 8;
  localparam int ACR_CTRL_DELAY_LSB = 12;
  localparam logic [15:0] ACR_CTRL_RESET = 16'h1120;

  // status register fields
  localparam int ACR_ST_RESET_BIT = 0;
  localparam int ACR_ST_CLKEXT_BIT = 1;
  localparam int ACR_ST_DATA_READY_N_BIT = 2;
  localparam int ACR_ST_BUSY_BIT = 3;
  localparam int ACR_ST_READY_BIT = 4;

  // command register fields
  localparam int ACR_CMD_START_BIT = 0;
  localparam int ACR_CMD_STOP_BIT = 1;
  localparam int ACR_CMD_RESET_BIT = 2;

  // master clock counts, with the start delay in ns
  localparam int ACR_POR_CYCLES = 65536;
  localparam int ACR_START_HOLD_TICKS = 512;
  localparam int ACR_RST_PIN_MIN_TICKS = 4;
  localparam longint ACR_START_DELAY_NS = 50000;
  localparam int ACR_DELAY_UNIT_TICKS =
    int'((ACR_START_DELAY_NS * ACR_NOMINAL_FCLK_HZ + 64'd999999999) / 1000000000);

  // filter modes: sinc1, sinc3, sinc4, sinc5, fir
  localparam logic [2:0] ACR_MODE_FIR = 3'h4;
  localparam logic [2:0] ACR_FILTER_ORDER [0:4] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h1};

  // conversion period in master clock ticks per data-rate index
  localparam int ACR_NUM_RATES = 17;
  localparam logic [21:0] ACR_PERIOD_TICKS [0:16] = '{
    22'h2D0000, 22'h168000, 22'h0B4000, 22'h06C6F1, 22'h05A000, 22'h024000,
    22'h01E000, 22'h012000, 22'h004800, 22'h001800, 22'h000C00, 22'h000600,
    22'h000400, 22'h000200, 22'h000180, 22'h000120, 22'h000100};

  typedef enum logic [2:0] {
    ACR_ST_POR, ACR_ST_HOLD, ACR_ST_IDLE, ACR_ST_DELAY, ACR_ST_SETTLE, ACR_ST_RUN
  } acr_state_type;
endpackage : acr_pkg

// [acr_sync_edge.sv]
`timescale 1ns/10ps
module acr_sync_edge #(
  parameter logic IDLE_LEVEL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;
  logic rise_reg;
  logic fall_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      // start from the pin's idle level so no false edge follows reset
      meta_reg <= IDLE_LEVEL;
      sync_reg <= IDLE_LEVEL;
      prev_reg <= IDLE_LEVEL;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      rise_reg <= sync_reg & ~prev_reg;
      fall_reg <= ~sync_reg & prev_reg;
    end
  end

  assign level = prev_reg;
  assign rise = rise_reg;
  assign fall = fall_reg;
endmodule : acr_sync_edge

// [tb.sv]
`timescale 1ns/10ps
module tb;
  localparam int TS = 12;
  localparam int TK = 16;
  localparam int DLY = acr_pkg::ACR_DELAY_UNIT_TICKS;
  localparam logic [3:0] A_CT = acr_pkg::ACR_OFS_CTRL;
  localparam logic [3:0] A_ST = acr_pkg::ACR_OFS_STATUS;
  localparam logic [3:0] A_CMD = acr_pkg::ACR_OFS_CMD;
  localparam logic [3:0] A_CNT = acr_pkg::ACR_OFS_COUNT;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic start_pin = 1'b0;
  logic reset_pin_n = 1'b1;
  logic ext_on = 1'b1;
  logic ext_clock_in;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd, q;
  logic avs_waitrequest, data_ready_n, clock_external;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int m;
  always #2 clk = ~clk;
  acr_ext_clk_src src (.enable(ext_on), .ext_clock_in(ext_clock_in));
  acr_conv_ctrl #(.POR_CYCLES(16), .TICK_SHIFT(TS)) uut (
    .clk(clk), .rst_b(rst_b), .start_pin(start_pin), .reset_pin_n(reset_pin_n),
    .ext_clock_in(ext_clock_in), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .data_ready_n(data_ready_n),
    .clock_external(clock_external));
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // tick phase and pin synchronisers make edge timing uncertain by a tick or so
  task automatic chk_near(input int got, input int exp, input int tol);
    samples_checked++;
    if (got < exp - tol || got > exp + tol) begin
      error_cnt++;
      $display("BAD %0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_near
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk);
    // only the bench timeout ends a stalled access
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rd);
    chk(rd & mask, exp);
  endtask : rdc
  task automatic wait_lvl(input logic lvl, output int c);
    c = 0;
    while (data_ready_n !== lvl && c < 40000) begin
      @(posedge clk);
      c++;
    end
  endtask : wait_lvl
  task automatic lat(input int ticks, input int tk, input int tol);
    int a;
    int b;
    wait_lvl(1'b1, a);
    wait_lvl(1'b0, b);
    chk_near(a + b, ticks * tk, tol);
  endtask : lat
  function automatic int per(input int i);
    per = int'(acr_pkg::ACR_PERIOD_TICKS[i] >> TS);
    if (per < 2) per = 2;
  endfunction : per
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk(32'(data_ready_n), 32'h0);
    rdc(A_ST, 32'h17, 32'h17);
    rdc(A_CT, 32'hFFFF, 32'h1120);
    wr(A_ST, 32'h1);
    rdc(A_ST, 32'h1, 32'h0);
    rdc(4'h1, 32'hFFFFFFFF, 32'h0);
    repeat (512 * TK + 64) @(posedge clk);
    rdc(A_ST, 32'h8, 32'h0);
    // every filter mode at one rate, then the delay field on its own
    for (int i = 0; i < 6; i++) begin
      m = (i < 5) ? i : 0;
      wr(A_CT, 32'(m) | 32'h28 | ((i == 5) ? 32'h1000 : 32'h0));
      wr(A_CMD, 32'h1);
      lat(int'(acr_pkg::ACR_FILTER_ORDER[m]) * per(5) + ((i == 5) ? DLY : 0), TK, 40);
    end
    wr(A_CT, 32'h128);
    wr(A_CMD, 32'h1);
    lat(per(5), TK, 40);
    // continuous mode: the second result comes one data period after the first
    lat(per(5), TK, 20);
    wr(A_CMD, 32'h2);
    repeat (2 * per(5) * TK) @(posedge clk);
    bus(1'b0, A_CNT, 32'h0, q);
    repeat (2 * per(5) * TK) @(posedge clk);
    rdc(A_CNT, 32'hFFFF, q & 32'hFFFF);
    start_pin <= 1'b1;
    lat(per(5), TK, 40);
    wr(A_CMD, 32'h4);
    lat(512 + DLY + per(4), TK, 64);
    rdc(A_ST, 32'h1, 32'h1);
    rdc(A_CT, 32'hFFFF, 32'h1120);
    start_pin <= 1'b0;
    repeat (2 * per(4) * TK) @(posedge clk);
    ext_on <= 1'b0;
    repeat (400) @(posedge clk);
    rdc(A_ST, 32'h2, 32'h0);
    wr(A_CT, 32'h28);
    wr(A_CMD, 32'h1);
    lat(per(5), acr_pkg::ACR_INT_OSC_DIV, 80);
    ext_on <= 1'b1;
    repeat (400) @(posedge clk);
    rdc(A_ST, 32'h2, 32'h2);
    chk(32'(clock_external), 32'h1);
    wr(A_CT, 32'h128);
    wr(A_ST, 32'h1);
    reset_pin_n <= 1'b0;
    repeat (16 * TK) @(posedge clk);
    reset_pin_n <= 1'b1;
    repeat (16) @(posedge clk);
    chk(32'(data_ready_n), 32'h1);
    rdc(A_ST, 32'h1, 32'h1);
    rdc(A_CT, 32'hFFFF, 32'h1120);
    stop_test();
  end
endmodule : tb
